// ### cmpreg_pkg.sv
// Constants and carrier types for the comparator mode and control registers.
// Functional notes
// (R1) Comparator1 output flag is read-only, 1 when positive input exceeds negative.
// (R2) Rising-edge flag sets on rising output edge, stays until software writes 0.
// (R3) Falling-edge flag sets on falling output edge, stays until software writes 0.
// (R4) Two-bit positive hysteresis field drives the comparator1 analog core.
// (R5) Two-bit negative hysteresis field drives the comparator1 analog core.
// (R6) Comparator0 two-bit speed/power mode is forwarded to its analog core.
// (R7) Comparator1 mode register holds same speed/power field in bits 1:0.
// (R8) Mode register bit 5 enables the rising-edge interrupt.
// (R9) Mode register bit 4 enables the falling-edge interrupt.
// (R10) Mode register bit 7 always reads 1; software must write 1.
// (R11) Mode register bit 6 reads 0 and ignores writes.
// (R12) Mode register bits 3:2 read 00 and ignore writes.
// (R13) Comparator0 mode register decodes at 0x9D in every page.
// (R14) Comparator1 mode register decodes at 0x9C only in page 0x0.
// (R15) Comparator1 control register decodes at 0x9A only in page 0x0.
// (R16) A disabled comparator is in low power and its output is forced 0.
// (R17) Edge flags set on edges regardless of interrupt enables.
// (R18) Output flag and edges use the raw output resynchronised to clock.
// (R19) Interrupt reaches the CPU only if source and global enables are set.
// (R20) Request is rise flag AND rise enable OR fall flag AND fall enable.
package cmpreg_pkg;

    // ========================================================================
    // Register addresses and page.
    localparam logic [7:0] CMPREG_ADDR_CMP1_CTRL = 8'h9A;
    localparam logic [7:0] CMPREG_ADDR_CMP1_MODE = 8'h9C;
    localparam logic [7:0] CMPREG_ADDR_CMP0_MODE = 8'h9D;
    localparam logic [7:0] CMPREG_PAGE_ZERO      = 8'h00;

    // ========================================================================
    // Field positions.
    localparam int CMPREG_BIT_ENABLE   = 7;
    localparam int CMPREG_BIT_OUT      = 6;
    localparam int CMPREG_BIT_RISE     = 5;
    localparam int CMPREG_BIT_FALL     = 4;
    localparam int CMPREG_HYP_HI       = 3;
    localparam int CMPREG_HYP_LO       = 2;
    localparam int CMPREG_HYN_HI       = 1;
    localparam int CMPREG_HYN_LO       = 0;
    localparam int CMPREG_MODE_HI      = 1;
    localparam int CMPREG_MODE_LO      = 0;

    // ========================================================================
    // Reset values and fixed read bits.
    localparam logic [1:0] CMPREG_MODE_RESET  = 2'h2;
    localparam logic [1:0] CMPREG_HYST_RESET  = 2'h0;
    localparam logic       CMPREG_FIXED_ONE   = 1'b1;
    localparam logic       CMPREG_FIXED_ZERO  = 1'b0;

    // Speed/power modes; mode 0 fastest, mode 3 lowest power.
    typedef enum logic [1:0] {
        CMPREG_MODE0,
        CMPREG_MODE1,
        CMPREG_MODE2,
        CMPREG_MODE3
    } cmpreg_mode_e;

    // Settings of one comparator's mode register.
    typedef struct packed {
        logic       rise_irq_enable;
        logic       fall_irq_enable;
        logic [1:0] speed_power_select;
    } cmpreg_mode_s;

    // Full block state.
    typedef struct packed {
        logic         cmp1_enable;
        logic         cmp1_rise_flag;
        logic         cmp1_fall_flag;
        logic [1:0]   cmp1_pos_hysteresis;
        logic [1:0]   cmp1_neg_hysteresis;
        cmpreg_mode_s cmp0_mode;
        cmpreg_mode_s cmp1_mode;
        logic         sync1;
        logic         sync2;
        logic         sync_prev;
        logic [7:0]   rdata;
        logic         cmp1_irq;
        logic         cmp0_irq;
    } cmpreg_state_s;

endpackage

// ### cmpreg_top.sv
// Comparator control and mode registers on the special function register bus.
`timescale 1ns/1ns
module cmpreg_top
    import cmpreg_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [7:0] sfr_page,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic       cmp1_raw_out,
    input  wire logic       cmp0_rise_flag,
    input  wire logic       cmp0_fall_flag,
    input  wire logic       cmp1_irq_src_enable,
    input  wire logic       global_irq_enable,
    output logic [7:0]      sfr_rdata,
    output logic            cmp1_enable,
    output logic [1:0]      cmp1_pos_hysteresis,
    output logic [1:0]      cmp1_neg_hysteresis,
    output logic [1:0]      cmp0_speed_power_select,
    output logic [1:0]      cmp1_speed_power_select,
    output logic            cmp0_irq_req,
    output logic            cmp1_irq_req
);

    // ========================================================================
    // Internal state.
    cmpreg_state_s st_reg;
    cmpreg_state_s st_next;
    logic [1:0]    rst_sync_reg;
    logic          rst_int_b;

    // ========================================================================
    // Reset synchroniser.
    // Internal reset released through two flops; asserted asynchronously.
    // The synchroniser has its own register because it runs on the pin
    // reset, while all other state runs on the synchronised copy; this way
    // every flop leaves reset on the same edge and none sees a runt release.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_int_b = rst_sync_reg[1];

    // ========================================================================
    // Decode and access helpers.
    // An address outside the three registers, or a page other than zero for
    // the two paged ones, hits nothing: writes are dropped and reads give 0.

    // Page-independent decode for the comparator0 mode register.
    function automatic logic hit_any(input logic [7:0] a,
                                     input logic [7:0] r);
        hit_any = (a == r);
    endfunction

    // Decode valid only in page zero.
    // The page compare is exact, so any page but zero misses.
    function automatic logic hit_p0(input logic [7:0] p,
                                    input logic [7:0] a,
                                    input logic [7:0] r);
        hit_p0 = (p == CMPREG_PAGE_ZERO) && (a == r);
    endfunction

    // Reads have no side effects, so polling the registers is always safe.
    // Mode register readback with fixed bits 7, 6 and 3:2.
    function automatic logic [7:0] mode_read(input cmpreg_mode_s m);
        mode_read = {CMPREG_FIXED_ONE, CMPREG_FIXED_ZERO,     // R10 R11
                     m.rise_irq_enable, m.fall_irq_enable,
                     2'b00, m.speed_power_select};            // R12
    endfunction

    // Mode register write; bits 7, 6 and 3:2 are discarded.
    // They have no storage, so bit 7 reads 1 whatever software wrote.
    function automatic cmpreg_mode_s mode_write(input logic [7:0] d);
        mode_write.rise_irq_enable    = d[CMPREG_BIT_RISE];   // R8
        mode_write.fall_irq_enable    = d[CMPREG_BIT_FALL];   // R9
        mode_write.speed_power_select = d[CMPREG_MODE_HI:CMPREG_MODE_LO];
    endfunction

    // ========================================================================
    // Next-state logic.
    // Next-state logic for registers, synchroniser, flags and requests.
    always_comb begin
        logic wr_ctrl;
        logic wr_m1;
        logic wr_m0;
        logic rise_ev;
        logic fall_ev;
        logic out_q;
        // Edges are seen between the second synchroniser flop and its copy.
        out_q   = st_reg.sync2;                                   // R1
        rise_ev = out_q && !st_reg.sync_prev;
        fall_ev = !out_q && st_reg.sync_prev;
        wr_ctrl = sfr_wr && hit_p0(sfr_page, sfr_addr,
                                   CMPREG_ADDR_CMP1_CTRL);        // R15
        wr_m1   = sfr_wr && hit_p0(sfr_page, sfr_addr,
                                   CMPREG_ADDR_CMP1_MODE);        // R14
        wr_m0   = sfr_wr && hit_any(sfr_addr, CMPREG_ADDR_CMP0_MODE); // R13
        st_next = st_reg;

        // Raw output passes two flops; a disabled comparator reads 0.
        // The enable gate sits ahead of the first flop, so turning the
        // comparator off shows up as a falling edge; software is expected
        // to clear both flags a little after any enable or mode change.
        st_next.sync1     = cmp1_raw_out && st_reg.cmp1_enable;   // R16
        st_next.sync2     = st_reg.sync1;                         // R18
        st_next.sync_prev = st_reg.sync2;

        // Register writes; fields outside each register's map are ignored.
        // A flag bit written here may still be overridden by an edge below.
        if (wr_ctrl) begin
            st_next.cmp1_enable         = sfr_wdata[CMPREG_BIT_ENABLE];
            st_next.cmp1_rise_flag      = sfr_wdata[CMPREG_BIT_RISE];
            st_next.cmp1_fall_flag      = sfr_wdata[CMPREG_BIT_FALL];
            st_next.cmp1_pos_hysteresis =
                sfr_wdata[CMPREG_HYP_HI:CMPREG_HYP_LO];           // R4
            st_next.cmp1_neg_hysteresis =
                sfr_wdata[CMPREG_HYN_HI:CMPREG_HYN_LO];           // R5
        end
        if (wr_m1) begin
            st_next.cmp1_mode = mode_write(sfr_wdata);            // R7
        end
        if (wr_m0) begin
            st_next.cmp0_mode = mode_write(sfr_wdata);            // R6
        end

        // Hardware set beats a same-cycle software clear.
        // An edge that lands while software clears the flag is never lost.
        // Writing 1 to a flag sets it, which lets software test the path.
        if (rise_ev) begin
            st_next.cmp1_rise_flag = 1'b1;                        // R2 R17
        end
        if (fall_ev) begin
            st_next.cmp1_fall_flag = 1'b1;                        // R3 R17
        end

        // Readback mux; unmapped addresses read zero.
        // Data stands one cycle after the strobe and is 0 otherwise, so
        // several register blocks can share the read bus through an OR.
        st_next.rdata = 8'h00;
        if (sfr_rd) begin
            if (hit_p0(sfr_page, sfr_addr, CMPREG_ADDR_CMP1_CTRL)) begin
                st_next.rdata = {st_reg.cmp1_enable, out_q,
                                 st_reg.cmp1_rise_flag,
                                 st_reg.cmp1_fall_flag,
                                 st_reg.cmp1_pos_hysteresis,
                                 st_reg.cmp1_neg_hysteresis};
            end else if (hit_p0(sfr_page, sfr_addr,
                                CMPREG_ADDR_CMP1_MODE)) begin
                st_next.rdata = mode_read(st_reg.cmp1_mode);
            end else if (hit_any(sfr_addr, CMPREG_ADDR_CMP0_MODE)) begin
                st_next.rdata = mode_read(st_reg.cmp0_mode);
            end
        end

        // Request gated by per-edge, source and global enables.
        // Requests are registered and so trail their flags by one cycle.
        // Comparator0 has no source enable here; its control lives outside.
        st_next.cmp1_irq = global_irq_enable && cmp1_irq_src_enable && // R19
            ((st_reg.cmp1_rise_flag && st_reg.cmp1_mode.rise_irq_enable) ||
             (st_reg.cmp1_fall_flag &&
              st_reg.cmp1_mode.fall_irq_enable));                 // R20
        st_next.cmp0_irq = global_irq_enable &&
            ((cmp0_rise_flag && st_reg.cmp0_mode.rise_irq_enable) ||
             (cmp0_fall_flag && st_reg.cmp0_mode.fall_irq_enable)); // R20
    end

    // ========================================================================
    // State register.
    // State register; reset values are the documented ones.
    // The synchroniser flops reset to 0, the idle level of a disabled
    // comparator, so no false edge is flagged as reset ends.
    // Each field is listed so none can slip past its reset value.
    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            st_reg.cmp1_enable         <= 1'b0;
            st_reg.cmp1_rise_flag      <= 1'b0;
            st_reg.cmp1_fall_flag      <= 1'b0;
            st_reg.cmp1_pos_hysteresis <= CMPREG_HYST_RESET;
            st_reg.cmp1_neg_hysteresis <= CMPREG_HYST_RESET;
            st_reg.cmp0_mode           <= '{1'b0, 1'b0, CMPREG_MODE_RESET};
            st_reg.cmp1_mode           <= '{1'b0, 1'b0, CMPREG_MODE_RESET};
            st_reg.sync1               <= 1'b0;
            st_reg.sync2               <= 1'b0;
            st_reg.sync_prev           <= 1'b0;
            st_reg.rdata               <= 8'h00;
            st_reg.cmp1_irq            <= 1'b0;
            st_reg.cmp0_irq            <= 1'b0;
        end else begin
            st_reg.cmp1_enable         <= st_next.cmp1_enable;
            st_reg.cmp1_rise_flag      <= st_next.cmp1_rise_flag;
            st_reg.cmp1_fall_flag      <= st_next.cmp1_fall_flag;
            st_reg.cmp1_pos_hysteresis <= st_next.cmp1_pos_hysteresis;
            st_reg.cmp1_neg_hysteresis <= st_next.cmp1_neg_hysteresis;
            st_reg.cmp0_mode           <= st_next.cmp0_mode;
            st_reg.cmp1_mode           <= st_next.cmp1_mode;
            st_reg.sync1               <= st_next.sync1;
            st_reg.sync2               <= st_next.sync2;
            st_reg.sync_prev           <= st_next.sync_prev;
            st_reg.rdata               <= st_next.rdata;
            st_reg.cmp1_irq            <= st_next.cmp1_irq;
            st_reg.cmp0_irq            <= st_next.cmp0_irq;
        end
    end

    // ========================================================================
    // Outputs.
    // Outputs come straight from state flops.
    // Nothing combinational reaches a pin, so the analog controls never
    // see a glitch while a write is decoded.
    assign sfr_rdata               = st_reg.rdata;
    assign cmp1_enable             = st_reg.cmp1_enable;
    assign cmp1_pos_hysteresis     = st_reg.cmp1_pos_hysteresis;
    assign cmp1_neg_hysteresis     = st_reg.cmp1_neg_hysteresis;
    assign cmp0_speed_power_select = st_reg.cmp0_mode.speed_power_select;
    assign cmp1_speed_power_select = st_reg.cmp1_mode.speed_power_select;
    assign cmp0_irq_req            = st_reg.cmp0_irq;
    assign cmp1_irq_req            = st_reg.cmp1_irq;

endmodule

// ### cmpreg_asserts.sv
// Port-level assertions for the comparator register block.
`timescale 1ns/1ns
module cmpreg_asserts (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic [7:0] sfr_page,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic       global_irq_enable,
    input wire logic       cmp1_irq_src_enable,
    input wire logic [7:0] sfr_rdata,
    input wire logic       cmp1_enable,
    input wire logic [1:0] cmp1_pos_hysteresis,
    input wire logic [1:0] cmp1_neg_hysteresis,
    input wire logic [1:0] cmp0_speed_power_select,
    input wire logic [1:0] cmp1_speed_power_select,
    input wire logic       cmp0_irq_req,
    input wire logic       cmp1_irq_req
);
    // ========================================================================
    // Decodes and request gates; page-zero registers must not move when another page is set.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence ctrl_wr_s;
        sfr_wr && sfr_page == 8'h00 && sfr_addr == 8'h9A;
    endsequence
    sequence mode1_wr_s;
        sfr_wr && sfr_page == 8'h00 && sfr_addr == 8'h9C;
    endsequence
    rd_fixed_a: assert property (sfr_rd && sfr_addr == 8'h9D |=>
        sfr_rdata[7:6] == 2'b10 && sfr_rdata[3:2] == 2'b00)
        else $error("fixed mode bits read wrong");
    c0_mode_a: assert property (sfr_wr && sfr_addr == 8'h9D |=>
        cmp0_speed_power_select == $past(sfr_wdata[1:0]))
        else $error("comparator0 mode not taken");
    c1_mode_a: assert property (mode1_wr_s |=>
        cmp1_speed_power_select == $past(sfr_wdata[1:0]))
        else $error("comparator1 mode not taken");
    ctrl_wr_a: assert property (ctrl_wr_s |=>
        {cmp1_enable, cmp1_pos_hysteresis, cmp1_neg_hysteresis}
        == $past({sfr_wdata[7], sfr_wdata[3:0]}))
        else $error("control fields not taken");
    page_gate_a: assert property (sfr_wr && sfr_page != 8'h00 &&
        sfr_addr inside {8'h9A, 8'h9C} |=> $stable({cmp1_enable,
        cmp1_pos_hysteresis, cmp1_neg_hysteresis, cmp1_speed_power_select}))
        else $error("write in wrong page took effect");
    unmapped_rd_a: assert property (sfr_rd && !(sfr_addr == 8'h9D ||
        sfr_page == 8'h00 && sfr_addr inside {8'h9A, 8'h9C}) |=>
        sfr_rdata == 8'h00) else $error("unmapped read not zero");
    c1_irq_gate_a: assert property (cmp1_irq_req |->
        $past(global_irq_enable && cmp1_irq_src_enable))
        else $error("comparator1 request without enables");
    c0_irq_gate_a: assert property (cmp0_irq_req |->
        $past(global_irq_enable)) else $error("comparator0 request ungated");
endmodule
bind cmpreg_top cmpreg_asserts u_cmpreg_asserts (.clk(clk), .rst_b(rst_b),
    .sfr_page(sfr_page), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .global_irq_enable(global_irq_enable),
    .cmp1_irq_src_enable(cmp1_irq_src_enable), .sfr_rdata(sfr_rdata),
    .cmp1_enable(cmp1_enable), .cmp1_pos_hysteresis(cmp1_pos_hysteresis),
    .cmp1_neg_hysteresis(cmp1_neg_hysteresis),
    .cmp0_speed_power_select(cmp0_speed_power_select),
    .cmp1_speed_power_select(cmp1_speed_power_select),
    .cmp0_irq_req(cmp0_irq_req), .cmp1_irq_req(cmp1_irq_req));

// ### cmpreg_cpu_model.sv
// CPU-side model that drives the special function register bus.
`timescale 1ns/1ns
module cmpreg_cpu_model (
    input  wire logic       clk,
    input  wire logic [7:0] sfr_rdata,
    output logic [7:0]      sfr_page,
    output logic [7:0]      sfr_addr,
    output logic [7:0]      sfr_wdata,
    output logic            sfr_wr,
    output logic            sfr_rd
);
    // ========================================================================
    // Between transfers the bus shows inverted address and data so a stale copy is never mistaken.
    initial begin
        {sfr_page, sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = 26'h000_0000;
    end
    // One strobe cycle; read data is taken just after the taking edge.
    task automatic xfer(input logic w, input logic [7:0] p, a, d,
                        output logic [7:0] q);
        @(posedge clk) #1;
        {sfr_page, sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = {p, a, d, w, !w};
        @(posedge clk) #1;
        q = sfr_rdata;
        {sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = {~a, ~d, 2'b00};
    endtask
endmodule

// ### cmpreg_tb_top.sv
// Self-checking testbench for the comparator register block.
`timescale 1ns/1ns
module cmpreg_tb_top import cmpreg_pkg::*;;
    logic       clk = 1'b0, rst_b = 1'b0, raw = 1'b0, rise0 = 1'b0;
    logic       src = 1'b0, glb = 1'b0, fall0 = 1'b0, wr, rd, en1, irq0, irq1;
    logic [7:0] page, addr, wdata, rdata, q;
    logic [1:0] hyp, hyn, md0, md1;
    int         fail_count = 0;
    int         n_checks = 0;
    cmpreg_top u_cmpreg_top (.clk(clk), .rst_b(rst_b), .sfr_page(page),
        .sfr_addr(addr), .sfr_wdata(wdata), .sfr_wr(wr), .sfr_rd(rd),
        .cmp1_raw_out(raw), .cmp0_rise_flag(rise0), .cmp0_fall_flag(fall0),
        .cmp1_irq_src_enable(src), .global_irq_enable(glb),
        .sfr_rdata(rdata), .cmp1_enable(en1), .cmp1_pos_hysteresis(hyp),
        .cmp1_neg_hysteresis(hyn), .cmp0_speed_power_select(md0),
        .cmp1_speed_power_select(md1), .cmp0_irq_req(irq0),
        .cmp1_irq_req(irq1));
    cmpreg_cpu_model u_cmpreg_cpu_model (.clk(clk), .sfr_rdata(rdata),
        .sfr_page(page), .sfr_addr(addr), .sfr_wdata(wdata), .sfr_wr(wr),
        .sfr_rd(rd));
    // ========================================================================
    // Clock, watchdog and shared tasks.
    initial begin
        forever #20 clk = ~clk;
    end
    initial begin
        #80000;
        fail_count++;
        give_verdict();
    end
    task automatic chk(input string n, input logic [7:0] s, e);
        n_checks++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr8(input logic [7:0] p, a, d);
        u_cmpreg_cpu_model.xfer(1'b1, p, a, d, q);
    endtask
    task automatic rd8(input logic [7:0] p, a, e);
        u_cmpreg_cpu_model.xfer(1'b0, p, a, 8'h00, q);
        chk("read data", q, e);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic give_verdict;
        $display("Checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ========================================================================
    // Tests; the flag path needs several cycles through the synchroniser.
    initial begin
        wt(5);
        rst_b = 1'b1;
        wt(3);
        rd8(8'h00, 8'h9D, 8'h82);
        rd8(8'h00, 8'h9C, 8'h82);
        rd8(8'h00, 8'h9A, 8'h00);
        rd8(8'h07, 8'h9D, 8'h82);
        rd8(8'h07, 8'h9C, 8'h00);
        rd8(8'h00, 8'h9B, 8'h00);
        $display("test reset values done");
        for (int m = 0; m < 4; m++) begin
            wr8(8'h05, 8'h9D, 8'hCC | 8'(m) | 8'(m << 4));
            wr8(8'h00, 8'h9C, 8'hCC | 8'(m) | 8'((3 - m) << 4));
            chk("mode0", {6'h00, md0}, 8'(m));
            chk("mode1", {6'h00, md1}, 8'(m));
            rd8(8'h05, 8'h9D, 8'h80 | 8'(m) | 8'(m << 4));
            rd8(8'h00, 8'h9C, 8'h80 | 8'(m) | 8'((3 - m) << 4));
        end
        for (int h = 0; h < 4; h++) begin
            wr8(8'h00, 8'h9A, 8'h40 | 8'(h << 2) | 8'(3 - h));
            chk("hyst", {4'h0, hyp, hyn}, 8'(h << 2) | 8'(3 - h));
            rd8(8'h00, 8'h9A, 8'(h << 2) | 8'(3 - h));
        end
        wr8(8'h01, 8'h9A, 8'h8F);
        chk("enable", {7'h00, en1}, 8'h00);
        rd8(8'h00, 8'h9A, 8'h0C);
        wr8(8'h01, 8'h9C, 8'hB3);
        rd8(8'h00, 8'h9C, 8'h83);
        $display("test modes and pages done");
        wr8(8'h00, 8'h9C, 8'hB0);
        wr8(8'h00, 8'h9A, 8'h80);
        chk("enable", {7'h00, en1}, 8'h01);
        {src, glb, raw} = 3'b111;
        wt(8);
        rd8(8'h00, 8'h9A, 8'hE0);
        chk("irq1", {7'h00, irq1}, 8'h01);
        wr8(8'h00, 8'h9A, 8'h80);
        wt(2);
        chk("irq1", {7'h00, irq1}, 8'h00);
        raw = 1'b0;
        wt(8);
        rd8(8'h00, 8'h9A, 8'h90);
        chk("irq1", {7'h00, irq1}, 8'h01);
        glb = 1'b0;
        wt(2);
        chk("irq1", {7'h00, irq1}, 8'h00);
        glb = 1'b1;
        wr8(8'h00, 8'h9C, 8'h80);
        wr8(8'h00, 8'h9A, 8'h80);
        raw = 1'b1;
        wt(8);
        rd8(8'h00, 8'h9A, 8'hE0);
        chk("irq1", {7'h00, irq1}, 8'h00);
        wr8(8'h00, 8'h9A, 8'h00);
        chk("enable", {7'h00, en1}, 8'h00);
        wt(8);
        rd8(8'h00, 8'h9A, 8'h10);
        $display("test comparator1 edges done");
        wr8(8'h03, 8'h9D, 8'hA0);
        rise0 = 1'b1;
        wt(2);
        chk("irq0", {7'h00, irq0}, 8'h01);
        glb = 1'b0;
        wt(2);
        chk("irq0", {7'h00, irq0}, 8'h00);
        glb = 1'b1;
        wr8(8'h03, 8'h9D, 8'h90);
        wt(2);
        chk("irq0", {7'h00, irq0}, 8'h00);
        fall0 = 1'b1;
        wt(2);
        chk("irq0", {7'h00, irq0}, 8'h01);
        $display("test comparator0 requests done");
        give_verdict();
    end
endmodule
